// file: rtl/cos_cfg.svh
// register map, field positions, reset values and counts for the comparator output sync block
// assumes inclusion by the package and the top module only
`ifndef COS_CFG_SVH
`define COS_CFG_SVH

`define COS_NUM_CMP         2
`define COS_ADDR_W          8
`define COS_DATA_W          32

// register byte offsets
`define COS_OFF_SHARED      8'h00
`define COS_OFF_OWN_A       8'h04
`define COS_OFF_OWN_B       8'h08
`define COS_OFF_IRQ_STATUS  8'h0c
`define COS_OFF_IRQ_CLEAR   8'h10
`define COS_OFF_IRQ_ENABLE  8'h14

// shared control field positions, two bits per field (bit of comparator a first)
`define COS_BIT_REF_SEL     0
`define COS_BIT_HYS         2
`define COS_BIT_SYNC        4
`define COS_BIT_MIRROR      6
`define COS_SHARED_W_MASK   8'h3f

// own control field positions
`define COS_BIT_ROUTE       0

// reset values
`define COS_RST_SHARED      6'h00
`define COS_RST_ROUTE       1'h0
`define COS_RST_IRQ         2'h0

`endif

// file: rtl/cos_pkg.sv
// types shared by the comparator output sync block
// assumes cos_cfg.svh is on the include path
`include "cos_cfg.svh"

package cos_pkg;

	// per-comparator settings handed to a channel
	typedef struct packed {
		logic ref_sel;
		logic hys_en;
		logic sync_en;
		logic route_en;
	} cos_chan_cfg_s;

	// apb request as seen by the slave
	typedef struct packed {
		logic                    sel;
		logic                    enable;
		logic                    write;
		logic [`COS_ADDR_W-1:0]  addr;
		logic [`COS_DATA_W-1:0]  wdata;
	} cos_apb_req_s;

	typedef logic [`COS_NUM_CMP-1:0] cos_cmp_vec_t;

endpackage : cos_pkg

// file: rtl/cos_channel.sv
// one comparator channel: output latch on timer clock fall, or plain pass
// assumes the falling-edge pulse is already in the clk_sys domain
`timescale 1ns/10ps

module cos_channel (
	// clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	// comparator and timer
	input  wire logic                   cmp_raw,
	input  wire logic                   tmr_fall,
	input  wire cos_pkg::cos_chan_cfg_s cfg,
	// result
	output logic                        cmp_out,
	output logic                        changed
);

	logic next_out;

	// latch only on timer clock fall when sync is on, else follow the comparator
	assign next_out = cfg.sync_en ? (tmr_fall ? cmp_raw : cmp_out) : cmp_raw;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cmp_out <= 1'b0;
			changed <= 1'b0;
		end else begin
			cmp_out <= next_out;
			changed <= next_out != cmp_out;
		end
	end

endmodule : cos_channel

// file: rtl/cos_top.sv
// comparator output sync block: apb registers, reference and hysteresis controls, output sync
// assumes all inputs synchronous to clk_sys; the timer source clock is sampled as a level
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`include "cos_cfg.svh"

module cos_top (
	// clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     rst,
	// apb slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [`COS_ADDR_W-1:0]   paddr,
	input  wire logic [`COS_DATA_W-1:0]   pwdata,
	output logic      [`COS_DATA_W-1:0]   prdata,
	output logic                          pready,
	output logic                          pslverr,
	// comparators and companion timer
	input  wire logic                     cmp_a_raw,
	input  wire logic                     cmp_b_raw,
	input  wire logic                     tmr_src_clk,
	output logic                          cmp_a_output,
	output logic                          cmp_b_output,
	// analog controls
	output logic [`COS_NUM_CMP-1:0]       ref_source_select,
	output logic [`COS_NUM_CMP-1:0]       ref_route_enable,
	output logic [`COS_NUM_CMP-1:0]       hysteresis_enable,
	// interrupt
	output logic                          irq
);

	logic [5:0]                    shared_ctl;
	logic [`COS_NUM_CMP-1:0]       route_ctl;
	cos_pkg::cos_cmp_vec_t         irq_status;
	cos_pkg::cos_cmp_vec_t         irq_enable;
	cos_pkg::cos_cmp_vec_t         cmp_raw;
	cos_pkg::cos_cmp_vec_t         cmp_out;
	cos_pkg::cos_cmp_vec_t         cmp_changed;
	cos_pkg::cos_apb_req_s         req;
	logic                          tmr_prev;
	logic                          tmr_fall;
	logic                          acc;
	logic                          wr;
	logic                          hit_shared;
	logic                          hit_own_a;
	logic                          hit_own_b;
	logic                          hit_status;
	logic                          hit_clear;
	logic                          hit_enable;
	logic                          hit_any;
	logic [`COS_DATA_W-1:0]        rd_mux;
	logic [`COS_NUM_CMP-1:0]       clr_bits;
	logic [5:0]                    next_shared;
	cos_pkg::cos_cmp_vec_t         next_status;
	logic [7:0]                    shared_rd;

	assign req      = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
	assign cmp_raw  = {cmp_b_raw, cmp_a_raw};
	assign tmr_fall = tmr_prev & ~tmr_src_clk;

	// one wait state: answer in the cycle after the access phase opens
	assign acc = req.sel & req.enable & ~pready;
	assign wr  = acc & req.write;

	// address decode
	assign hit_shared = req.addr == `COS_OFF_SHARED;
	assign hit_own_a  = req.addr == `COS_OFF_OWN_A;
	assign hit_own_b  = req.addr == `COS_OFF_OWN_B;
	assign hit_status = req.addr == `COS_OFF_IRQ_STATUS;
	assign hit_clear  = req.addr == `COS_OFF_IRQ_CLEAR;
	assign hit_enable = req.addr == `COS_OFF_IRQ_ENABLE;
	assign hit_any    = hit_shared | hit_own_a | hit_own_b | hit_status | hit_clear | hit_enable;

	// mirror bits sit beside the control bits so one read returns both outputs
	assign shared_rd = {cmp_out, shared_ctl};

	// read selection has no side effect on any state
	assign rd_mux = hit_shared ? {24'h000000, shared_rd} :
	                hit_own_a  ? {31'h00000000, route_ctl[0]} :
	                hit_own_b  ? {31'h00000000, route_ctl[1]} :
	                hit_status ? {30'h00000000, irq_status} :
	                hit_enable ? {30'h00000000, irq_enable} :
	                32'h00000000;

	assign next_shared = (wr & hit_shared) ? req.wdata[5:0] : shared_ctl;
	assign clr_bits    = (wr & hit_clear) ? req.wdata[`COS_NUM_CMP-1:0] : 2'h0;
	// a change in the same cycle as its clear is kept
	assign next_status = (irq_status & ~clr_bits) | cmp_changed;

	// bus answer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= acc;
			pslverr <= acc & ~hit_any;
			prdata  <= (acc & ~req.write) ? rd_mux : 32'h00000000;
		end
	end

	// control registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			shared_ctl <= `COS_RST_SHARED;
			route_ctl  <= {`COS_NUM_CMP{`COS_RST_ROUTE}};
			irq_enable <= `COS_RST_IRQ;
		end else begin
			shared_ctl <= next_shared;
			if (wr & hit_own_a) begin
				route_ctl[0] <= req.wdata[`COS_BIT_ROUTE];
			end
			if (wr & hit_own_b) begin
				route_ctl[1] <= req.wdata[`COS_BIT_ROUTE];
			end
			if (wr & hit_enable) begin
				irq_enable <= req.wdata[`COS_NUM_CMP-1:0];
			end
		end
	end

	// interrupt status and timer clock sampling
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_status <= `COS_RST_IRQ;
			irq        <= 1'b0;
			tmr_prev   <= 1'b0;
		end else begin
			irq_status <= next_status;
			irq        <= |(next_status & irq_enable);
			tmr_prev   <= tmr_src_clk;
		end
	end

	// analog control outputs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ref_source_select <= '0;
			ref_route_enable  <= '0;
			hysteresis_enable <= '0;
		end else begin
			ref_source_select <= next_shared[`COS_BIT_REF_SEL +: 2];
			ref_route_enable  <= route_ctl;
			hysteresis_enable <= next_shared[`COS_BIT_HYS +: 2];
		end
	end

	// one channel per comparator
	genvar gi;
	generate
		for (gi = 0; gi < `COS_NUM_CMP; gi = gi + 1) begin : g_chan
			cos_pkg::cos_chan_cfg_s ch_cfg;
			assign ch_cfg = '{ref_sel:  shared_ctl[`COS_BIT_REF_SEL + gi],
			                  hys_en:   shared_ctl[`COS_BIT_HYS + gi],
			                  sync_en:  shared_ctl[`COS_BIT_SYNC + gi],
			                  route_en: route_ctl[gi]};
			cos_channel u_chan (
				.clk_sys  (clk_sys),
				.rst      (rst),
				.cmp_raw  (cmp_raw[gi]),
				.tmr_fall (tmr_fall),
				.cfg      (ch_cfg),
				.cmp_out  (cmp_out[gi]),
				.changed  (cmp_changed[gi])
			);
		end
	endgenerate

	assign cmp_a_output = cmp_out[0];
	assign cmp_b_output = cmp_out[1];

endmodule : cos_top

// file: verification/cos_timer_model.sv
// companion timer model: source clock maker and gated counter
// assumes run and gate synchronous to clk_sys
`timescale 1ns/10ps
module cos_timer_model (
	// clock, reset, control
	input  wire logic       clk_sys, rst, run, gate,
	// source clock and count
	output logic            tmr_src_clk,
	output logic [7:0]      count
);
	logic [1:0] div;
	always_ff @(posedge clk_sys) begin
		if (rst) div <= 2'h0;
		else if (run) div <= div + 2'h1;
		if (rst) tmr_src_clk <= 1'b0;
		else if (run && div == 2'h3) tmr_src_clk <= ~tmr_src_clk;
	end
	// rising edge only, no prescaler, no input synchronizer
	// counted at the clk_sys edge where the source clock rises, so the gate is sampled race-free
	always_ff @(posedge clk_sys) begin
		if (rst) count <= 8'h00;
		else if (run && div == 2'h3 && !tmr_src_clk && gate) count <= count + 8'h01;
	end
endmodule : cos_timer_model

// file: verification/cos_sva.sv
// assertions on the cos_top ports
// assumes the bind at the foot reaches every cos_top
`timescale 1ns/10ps
module cos_sva (
	// apb
	input wire logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata, prdata,
	// comparators and controls
	input wire logic        cmp_a_raw, cmp_b_raw, tmr_src_clk, cmp_a_output, cmp_b_output,
	input wire logic [1:0]  ref_source_select, ref_route_enable, hysteresis_enable
);
	logic [5:0] sh;
	logic [1:0] rt;
	logic       tp;
	wire        tk = psel && penable && !pready && pwrite;
	wire        fl = tp && !tmr_src_clk;
	always_ff @(posedge clk_sys) begin
		tp <= rst ? 1'b0 : tmr_src_clk;
		if (rst) sh <= 6'h00;
		else if (tk && paddr == 8'h00) sh <= pwdata[5:0];
		if (rst) rt <= 2'h0;
		else if (tk && paddr == 8'h04) rt[0] <= pwdata[0];
		else if (tk && paddr == 8'h08) rt[1] <= pwdata[0];
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_ans; psel && penable && !pready |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("no ready");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready too long");
	property p_pass;
		sh[5:4] == 2'h0 |=> {cmp_b_output, cmp_a_output} == $past({cmp_b_raw, cmp_a_raw});
	endproperty
	a_pass: assert property (p_pass) else $error("pass output");
	property p_cap; sh[4] && fl |=> cmp_a_output == $past(cmp_a_raw); endproperty
	a_cap: assert property (p_cap) else $error("no latch");
	property p_hold; sh[5] && !fl |=> $stable(cmp_b_output); endproperty
	a_hold: assert property (p_hold) else $error("latch not held");
	// select and hysteresis outputs load at the same edge as the control register
	property p_ref; ref_source_select == sh[1:0]; endproperty
	a_ref: assert property (p_ref) else $error("ref select");
	property p_hys; hysteresis_enable == sh[3:2]; endproperty
	a_hys: assert property (p_hys) else $error("hysteresis");
	// route output trails the route register by one edge
	property p_route; !$past(rst) |-> ref_route_enable == $past(rt); endproperty
	a_route: assert property (p_route) else $error("route");
	property p_mir;
		pready && !pwrite && paddr == 8'h00 |->
			prdata[7:6] == $past({cmp_b_output, cmp_a_output});
	endproperty
	a_mir: assert property (p_mir) else $error("mirror");
	c_cap: cover property (sh[4] && fl);
	c_err: cover property (pready && pslverr);
	c_irq: cover property ($rose(irq));
endmodule : cos_sva
bind cos_top cos_sva u_sva (.*);

// file: verification/comparator_output_sync_tb.sv
// self-checking bench for cos_top with the companion timer model
// assumes cos_sva is bound to cos_top
`timescale 1ns/10ps
module comparator_output_sync_tb;
	logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq, run, er;
	logic        cmp_a_raw, cmp_b_raw, tmr_src_clk, cmp_a_output, cmp_b_output;
	logic [7:0]  paddr, cnt;
	logic [31:0] pwdata, prdata, rd, v;
	integer      seed;
	logic [1:0]  ref_source_select, ref_route_enable, hysteresis_enable, r;
	int          mismatches, comparisons;
	cos_top dut (.*);
	cos_timer_model tmr (.clk_sys(clk_sys), .rst(rst), .run(run), .gate(cmp_a_output),
		.tmr_src_clk(tmr_src_clk), .count(cnt));
	task automatic chk(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic xf(input logic w, input logic [7:0] ad, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : xf
	// next output pair: synced bits take raw only on a timer clock fall, others follow raw
	function automatic logic [1:0] exp_out(input logic [1:0] sync, held, raw, input logic fall);
		exp_out = (sync & (fall ? raw : held)) | (~sync & raw);
	endfunction : exp_out
	// random comparator levels; outputs checked each cycle against the expected pair
	task automatic rnd(input int n, input logic [1:0] sync);
		logic [1:0] want;
		logic       tq;
		want = {cmp_b_raw, cmp_a_raw};
		tq   = tmr_src_clk;
		repeat (n) begin
			v = $random(seed);
			{cmp_b_raw, cmp_a_raw} <= v[1:0];
			@(posedge clk_sys);
			chk("outputs", {cmp_b_output, cmp_a_output}, want);
			want = exp_out(sync, want, v[1:0], tq & ~tmr_src_clk);
			tq   = tmr_src_clk;
		end
	endtask : rnd
	task automatic tally_and_finish;
		if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		mismatches++;
		tally_and_finish();
	end
	initial begin
		seed = 32'hf0026ce2;
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, cmp_a_raw, cmp_b_raw, run, r} = '0;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		for (int i = 0; i < 6; i++) begin
			xf(1'b0, 8'(i * 4), 32'h0);
			chk("reset value", rd, 32'h0);
		end
		xf(1'b0, 8'h20, 32'h0);
		chk("unmapped err", er, 32'h1);
		chk("unmapped data", rd, 32'h0);
		repeat (8) begin
			v = $random(seed);
			xf(1'b1, 8'h00, v);
			chk("ref select", ref_source_select, v[1:0]);
			chk("hysteresis", hysteresis_enable, v[3:2]);
			xf(1'b1, {4'h0, v[6], ~v[6], 2'h0}, v[7]);
			r[v[6]] = v[7];
			repeat (2) @(posedge clk_sys);
			chk("route", ref_route_enable, r);
			xf(1'b0, 8'h00, 32'h0);
			chk("read back", rd[5:0], v[5:0]);
		end
		xf(1'b1, 8'h00, 32'h0);
		xf(1'b1, 8'h14, 32'h3);
		xf(1'b1, 8'h10, 32'h3);
		cmp_a_raw <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk("irq raised", irq, 32'h1);
		xf(1'b0, 8'h00, 32'h0);
		chk("mirror", rd[7:6], 32'h1);
		xf(1'b0, 8'h0c, 32'h0);
		chk("status kept", rd, 32'h1);
		xf(1'b1, 8'h14, 32'h2);
		chk("irq masked", irq, 32'h0);
		xf(1'b1, 8'h10, 32'h1);
		xf(1'b0, 8'h0c, 32'h0);
		chk("status cleared", rd, 32'h0);
		rnd(40, 2'h0);
		xf(1'b1, 8'h00, 32'h30);
		run <= 1'b1;
		rnd(60, 2'h3);
		{cmp_b_raw, cmp_a_raw} <= 2'h3;
		repeat (20) @(posedge clk_sys);
		run <= 1'b0;
		repeat (10) @(posedge clk_sys);
		{cmp_b_raw, cmp_a_raw} <= 2'h0;
		repeat (10) @(posedge clk_sys);
		chk("held", {cmp_b_output, cmp_a_output}, 32'h3);
		run <= 1'b1;
		repeat (20) @(posedge clk_sys);
		chk("latched", {cmp_b_output, cmp_a_output}, 32'h0);
		chk("timer counted", cnt != 8'h00, 32'h1);
		tally_and_finish();
	end
endmodule : comparator_output_sync_tb
